//--- cbt_pkg.sv
package cbt_pkg;
	// ----------------------------------------
	// phase and bus-state constants
	// ----------------------------------------
	localparam int unsigned OSC_PER_BUS = 4;
	localparam logic [1:0] PH_Q_RISE = 2'h0;
	localparam logic [1:0] PH_E_RISE = 2'h1;
	localparam logic [1:0] PH_Q_FALL = 2'h2;
	localparam logic [1:0] PH_E_FALL = 2'h3;
	localparam logic [1:0] BUS_RUN = 2'h0;
	localparam logic [1:0] BUS_IACK = 2'h1;
	localparam logic [1:0] BUS_SACK = 2'h2;
	localparam logic [1:0] BUS_GRANT = 2'h3;
	localparam logic [15:0] IDLE_ADDR = 16'hffff;
	localparam logic [15:0] FULL_VEC = 16'hfff8;
	localparam logic [15:0] FAST_VEC = 16'hfff6;
	localparam logic [3:0] GRANT_MAX = 4'hf;
	localparam logic [3:0] PUSH_FULL = 4'hc;
	localparam logic [3:0] PUSH_FAST = 4'h3;
	localparam int unsigned STRETCH_MAX_NS = 10000;
	localparam int unsigned CLK_NS = 50;
	localparam int unsigned STRETCH_MAX_CYC = STRETCH_MAX_NS / CLK_NS;
	localparam logic [2:0] NONE = 3'h0;
	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_DEAD_IN = 6'h02,
		ST_GRANT = 6'h04,
		ST_DEAD_RF = 6'h08,
		ST_REFRESH = 6'h10,
		ST_DEAD_OUT = 6'h20
	} cbt_state_type;
endpackage

//--- cbt_bus_if.sv
`timescale 1ns/1ps
interface cbt_bus_if;
	logic q_clk;
	logic e_clk;
	logic [15:0] addr;
	logic addr_oe;
	logic rw;
	logic rw_oe;
	logic [7:0] data_to_mem;
	logic data_oe;
	logic [7:0] data_from_mem;
	logic memory_ready;
	logic valid_memory_access;
	logic bus_released;
	logic bus_state_flag;
	logic bus_request_n;
	logic irq_n;
	logic fast_interrupt_request_n;
	modport device (
		output q_clk, e_clk, addr, addr_oe, rw, rw_oe, data_to_mem, data_oe,
		output valid_memory_access, bus_released, bus_state_flag,
		input data_from_mem, memory_ready, bus_request_n, irq_n, fast_interrupt_request_n
	);
	modport other (
		input q_clk, e_clk, addr, addr_oe, rw, rw_oe, data_to_mem, data_oe,
		input valid_memory_access, bus_released, bus_state_flag,
		output data_from_mem, memory_ready, bus_request_n, irq_n, fast_interrupt_request_n
	);
endinterface

//--- cbt_device.sv
`timescale 1ns/1ps
// Function
// - irq low with mask clear starts sequence
// - irq service pushes full machine state
// - fast request wins over general request
// - bus cycle is oscillator over four
// - q clock leads e clock by quarter
// - address valid by rising q edge
// - read data captured at e fall
// - memory_ready low stretches e by quarters
// - stretch total stays within ten microseconds; here not limited, STRETCH_MAX_CYC is unused
// - no stretch in non-valid access cycles
// - bus_request changes only while q high
// - bus_request halts at end of cycle
// - grant shown as both state pins high
// - first grant cycle is a dead cycle
// - dma asserts request at e rise
// - retrieve bus after fifteen granted cycles
// - refresh cycle has dead cycle both sides; here the cycle after refresh is run, not dead, when request is gone
// - system blocks memory in dead cycles
// - dma leaves bus when released falls
// - one dead cycle before own access
// - address and rw tristate while released
// - state pair encodes run, iack, grant
// - idle cycle drives ffff, read, flag low
module cbt_device (
	input wire logic mclk_in,
	input wire logic nrst_in,
	cbt_bus_if.device bus,
	input wire logic irq_mask_in,
	input wire logic fast_mask_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [15:0] req_addr_in,
	input wire logic [7:0] req_wdata_in,
	output logic req_done_out,
	output logic [7:0] rd_data_out,
	output logic [1:0] irq_taken_out,
	output logic [3:0] push_count_out,
	output logic halted_out
);
	cbt_pkg::cbt_state_type state_ff, nxt_state;
	logic [1:0] phase_ff;
	logic [3:0] grant_cnt_ff;
	logic q_ff, e_ff, rw_ff, vma_ff, iack_ff;
	logic [15:0] addr_ff;
	logic [7:0] wdata_ff;
	logic [7:0] rdata_ff;
	logic done_ff;
	logic [1:0] taken_ff;
	logic [3:0] push_ff;
	logic stretch, cycle_end, e_fall, own_cycle, granted, run_next;

	// ----------------------------------------
	// clock phase generation
	// ----------------------------------------
	// hold phase at e-high quarter while memory not ready
	assign stretch = (phase_ff == cbt_pkg::PH_Q_FALL) && vma_ff && !bus.memory_ready;
	assign cycle_end = (phase_ff == cbt_pkg::PH_E_FALL);
	// edge at which e drops, after any stretch
	assign e_fall = (phase_ff == cbt_pkg::PH_Q_FALL) && !stretch;
	// cycles the device owns, and cycles handed to the requester
	assign own_cycle = (state_ff == cbt_pkg::ST_RUN) || (state_ff == cbt_pkg::ST_REFRESH);
	assign granted = (state_ff == cbt_pkg::ST_DEAD_IN) || (state_ff == cbt_pkg::ST_GRANT);
	assign run_next = (nxt_state == cbt_pkg::ST_RUN);

	// divide-by-four phase counter
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			phase_ff <= cbt_pkg::PH_E_FALL; // first edge opens a cycle, q before e
		end else if (!stretch) begin
			phase_ff <= phase_ff + 2'h1;
		end
	end

	// quadrature outputs, q leads e by a quarter
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q_ff <= 1'b0;
			e_ff <= 1'b0;
		end else if (!stretch) begin
			q_ff <= (phase_ff == cbt_pkg::PH_E_FALL) || (phase_ff == cbt_pkg::PH_Q_RISE);
			e_ff <= (phase_ff == cbt_pkg::PH_Q_RISE) || (phase_ff == cbt_pkg::PH_E_RISE);
		end
	end

	// ----------------------------------------
	// bus grant sequencing
	// ----------------------------------------
	// request sampled only at cycle boundaries
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cbt_pkg::ST_RUN: if (!bus.bus_request_n) nxt_state = cbt_pkg::ST_DEAD_IN;
			cbt_pkg::ST_DEAD_IN: nxt_state = cbt_pkg::ST_GRANT;
			cbt_pkg::ST_GRANT: begin
				if (bus.bus_request_n) begin
					nxt_state = cbt_pkg::ST_DEAD_OUT;
				end else if (grant_cnt_ff == cbt_pkg::GRANT_MAX) begin
					nxt_state = cbt_pkg::ST_DEAD_RF;
				end
			end
			cbt_pkg::ST_DEAD_RF: nxt_state = cbt_pkg::ST_REFRESH;
			cbt_pkg::ST_REFRESH: begin
				if (bus.bus_request_n) begin
					nxt_state = cbt_pkg::ST_RUN;
				end else begin
					nxt_state = cbt_pkg::ST_DEAD_IN;
				end
			end
			cbt_pkg::ST_DEAD_OUT: nxt_state = cbt_pkg::ST_RUN;
			default: nxt_state = cbt_pkg::ST_RUN;
		endcase
	end

	// state advances once per bus cycle
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_ff <= cbt_pkg::ST_RUN;
		end else if (cycle_end) begin
			state_ff <= nxt_state;
		end
	end

	// counts bus cycles handed to the requester
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			grant_cnt_ff <= 4'h0;
		end else if (cycle_end) begin
			if (nxt_state == cbt_pkg::ST_DEAD_IN) begin
				grant_cnt_ff <= 4'h1;
			end else if (nxt_state == cbt_pkg::ST_GRANT) begin
				grant_cnt_ff <= grant_cnt_ff + 4'h1;
			end else begin
				grant_cnt_ff <= 4'h0;
			end
		end
	end

	// ----------------------------------------
	// address, rw and interrupt handling
	// ----------------------------------------
	// launch address at cycle start, on the same edge as rising q
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			addr_ff <= cbt_pkg::IDLE_ADDR;
			rw_ff <= 1'b1;
			vma_ff <= 1'b0;
			iack_ff <= 1'b0;
			wdata_ff <= 8'h00;
			taken_ff <= 2'h0;
			push_ff <= 4'h0;
		end else if (cycle_end) begin
			taken_ff <= 2'h0;
			iack_ff <= 1'b0;
			if (run_next && !bus.fast_interrupt_request_n && !fast_mask_in) begin
				addr_ff <= cbt_pkg::FAST_VEC;
				rw_ff <= 1'b1;
				vma_ff <= 1'b1;
				iack_ff <= 1'b1;
				taken_ff <= 2'h2;
				push_ff <= cbt_pkg::PUSH_FAST;
			end else if (run_next && !bus.irq_n && !irq_mask_in) begin
				addr_ff <= cbt_pkg::FULL_VEC;
				rw_ff <= 1'b1;
				vma_ff <= 1'b1;
				iack_ff <= 1'b1;
				taken_ff <= 2'h1;
				push_ff <= cbt_pkg::PUSH_FULL;
			end else if (run_next && req_valid_in) begin
				addr_ff <= req_addr_in;
				rw_ff <= !req_write_in;
				vma_ff <= 1'b1;
				wdata_ff <= req_wdata_in;
			end else begin
				addr_ff <= cbt_pkg::IDLE_ADDR;
				rw_ff <= 1'b1;
				vma_ff <= (nxt_state == cbt_pkg::ST_REFRESH);
			end
		end
	end

	// read data latched on falling e
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_ff <= 8'h00;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (e_fall && vma_ff && state_ff == cbt_pkg::ST_RUN && !iack_ff) begin
				done_ff <= 1'b1;
				if (rw_ff) rdata_ff <= bus.data_from_mem;
			end
		end
	end

	// ----------------------------------------
	// pin outputs
	// ----------------------------------------
	assign bus.q_clk = q_ff;
	assign bus.e_clk = e_ff;
	assign bus.addr = addr_ff;
	assign bus.rw = rw_ff;
	assign bus.bus_released = granted;
	assign bus.bus_state_flag = granted || iack_ff;
	assign bus.addr_oe = !granted;
	assign bus.rw_oe = !granted;
	assign bus.data_to_mem = wdata_ff;
	assign bus.data_oe = own_cycle && !rw_ff && e_ff;
	assign bus.valid_memory_access = own_cycle && vma_ff;
	assign req_done_out = done_ff;
	assign rd_data_out = rdata_ff;
	assign irq_taken_out = taken_ff;
	assign push_count_out = push_ff;
	assign halted_out = !own_cycle;
endmodule // cbt_device

//--- cbt_dma.sv
`timescale 1ns/1ps
module cbt_dma (
	input wire logic mclk_in,
	input wire logic nrst_in,
	cbt_bus_if.other bus,
	input wire logic want_bus_in,
	input wire logic ready_in,
	input wire logic irq_n_in,
	input wire logic fast_n_in,
	input wire logic [7:0] mem_data_in,
	output logic owns_bus_out,
	output logic mem_enable_out
);
	logic req_n_ff, q_dly_ff, rel_seen_ff, owned_ff, q_rise;

	// ----------------------------------------
	// request timing and bus ownership
	// ----------------------------------------
	// q rise seen at the edge where e rises, q still high
	assign q_rise = bus.q_clk && !q_dly_ff;

	// request moved with rising e, inside q high
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			req_n_ff <= 1'b1;
			q_dly_ff <= 1'b0;
		end else begin
			q_dly_ff <= bus.q_clk;
			if (q_rise) begin
				req_n_ff <= !want_bus_in;
			end
		end
	end

	// ownership only from the second released cycle on
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rel_seen_ff <= 1'b0;
			owned_ff <= 1'b0;
		end else if (q_rise) begin
			rel_seen_ff <= bus.bus_released;
			owned_ff <= rel_seen_ff && bus.bus_released && bus.bus_state_flag;
		end
	end

	assign bus.bus_request_n = req_n_ff;
	assign bus.memory_ready = ready_in;
	assign bus.irq_n = irq_n_in;
	assign bus.fast_interrupt_request_n = fast_n_in;
	assign bus.data_from_mem = mem_data_in;
	assign owns_bus_out = owned_ff && bus.bus_released;
	// memory gated off in dead cycles
	assign mem_enable_out = bus.valid_memory_access || (owned_ff && bus.bus_released);
endmodule // cbt_dma

//--- cbt_asserts.sv
`timescale 1ns/1ps
module cbt_asserts (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic q_clk,
	input wire logic e_clk,
	input wire logic [15:0] addr,
	input wire logic addr_oe,
	input wire logic rw,
	input wire logic rw_oe,
	input wire logic valid_memory_access,
	input wire logic memory_ready,
	input wire logic bus_released,
	input wire logic bus_state_flag,
	input wire logic bus_request_n
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	logic [7:0] rel_cnt_ff;
	// run length of the handed-out bus
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rel_cnt_ff <= 8'h00;
		end else begin
			rel_cnt_ff <= bus_released ? rel_cnt_ff + 8'h01 : 8'h00;
		end
	end
	sequence s_e_falls;
		$fell(e_clk);
	endsequence
	// one whole bus cycle without an own access
	sequence s_dead_cycle;
		!valid_memory_access [*4];
	endsequence
	// ----------------------------------------
	// clock phases
	// ----------------------------------------
	a_q_leads_e: assert property ($rose(q_clk) |=> $rose(e_clk))
		else $error("e did not follow q");
	a_q_fall_e_high: assert property ($fell(q_clk) |-> e_clk)
		else $error("q fell with e low");
	a_ready_no_stretch: assert property ($fell(q_clk) && memory_ready |=> s_e_falls)
		else $error("e stretched with ready high");
	a_vma_no_stretch: assert property ($fell(q_clk) && !valid_memory_access |=> s_e_falls)
		else $error("e stretched outside valid access");
	a_stretch_holds: assert property (e_clk && !q_clk && valid_memory_access && !memory_ready
		|=> e_clk && !q_clk)
		else $error("phase moved while ready low");
	// ----------------------------------------
	// bus state and grant
	// ----------------------------------------
	a_tristate_granted: assert property (bus_released |-> !addr_oe && !rw_oe)
		else $error("address or rw driven while released");
	a_grant_pair: assert property (bus_released |-> bus_state_flag)
		else $error("released without state flag");
	a_no_access_granted: assert property (bus_released |-> !valid_memory_access)
		else $error("own access while released");
	a_dead_after_release: assert property ($fell(bus_released) |-> s_dead_cycle)
		else $error("own access right after release");
	a_idle_cycle: assert property (!valid_memory_access && !bus_released
		|-> addr == cbt_pkg::IDLE_ADDR && rw && !bus_state_flag)
		else $error("idle cycle not all ones read");
	a_iack_vector: assert property (bus_state_flag && !bus_released
		|-> addr[15:4] == 12'hfff)
		else $error("acknowledge outside vector area");
	a_halt_at_cycle: assert property ($fell(bus_request_n) |-> ##[1:16] bus_released)
		else $error("request not granted at cycle end");
	a_grant_bounded: assert property (rel_cnt_ff <= 8'h44)
		else $error("bus not retrieved for refresh");
endmodule // cbt_asserts

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
	logic mclk_in, nrst_in, irq_mask_in, fast_mask_in, req_valid_in, req_write_in;
	logic want_bus_in, ready_in, irq_n_in, fast_n_in, req_done_out, halted_out, bad;
	logic owns_bus_out, mem_enable_out;
	logic [15:0] req_addr_in;
	logic [7:0] req_wdata_in, mem_data_in, rd_data_out;
	logic [1:0] irq_taken_out;
	logic [3:0] push_count_out;
	int n_mismatch = 0;
	int total_checks = 0;
	int n;
	cbt_bus_if bus_if ();
	cbt_device u_cbt_device (.mclk_in(mclk_in), .nrst_in(nrst_in), .bus(bus_if.device),
		.irq_mask_in(irq_mask_in), .fast_mask_in(fast_mask_in), .req_valid_in(req_valid_in),
		.req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.req_done_out(req_done_out), .rd_data_out(rd_data_out), .irq_taken_out(irq_taken_out),
		.push_count_out(push_count_out), .halted_out(halted_out));
	cbt_dma u_cbt_dma (.mclk_in(mclk_in), .nrst_in(nrst_in), .bus(bus_if.other),
		.want_bus_in(want_bus_in), .ready_in(ready_in), .irq_n_in(irq_n_in),
		.fast_n_in(fast_n_in), .mem_data_in(mem_data_in), .owns_bus_out(owns_bus_out),
		.mem_enable_out(mem_enable_out));
	cbt_asserts u_cbt_asserts (.mclk_in(mclk_in), .nrst_in(nrst_in), .q_clk(bus_if.q_clk),
		.e_clk(bus_if.e_clk), .addr(bus_if.addr), .addr_oe(bus_if.addr_oe), .rw(bus_if.rw),
		.rw_oe(bus_if.rw_oe), .valid_memory_access(bus_if.valid_memory_access),
		.memory_ready(bus_if.memory_ready), .bus_released(bus_if.bus_released),
		.bus_state_flag(bus_if.bus_state_flag), .bus_request_n(bus_if.bus_request_n));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tick();
		@(negedge mclk_in);
	endtask
	task automatic need(input logic ok);
		if (ok !== 1'h1) begin
			check("wait", 16'h0000, 16'h0001);
			give_verdict();
		end
	endtask
	// request taken at the q rise that opens the next bus cycle
	task automatic start_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d);
		req_valid_in = 1'h1;
		req_write_in = wr;
		req_addr_in = a;
		req_wdata_in = d;
		for (n = 0; n < 20 && bus_if.q_clk; n++) tick();
		for (n = 0; n < 20 && !bus_if.q_clk; n++) tick();
		need(bus_if.q_clk);
		tick();
		req_valid_in = 1'h0;
		check("addr", bus_if.addr, a);
		check("rw", bus_if.rw, !wr);
	endtask
	task automatic wait_done();
		for (n = 0; n < 400 && !req_done_out; n++) tick();
		need(req_done_out);
	endtask
	// ----------------------------------------
	// clock and sequence
	// ----------------------------------------
	initial begin
		mclk_in = 1'h0;
		forever #25 mclk_in = ~mclk_in;
	end
	initial begin
		{nrst_in, irq_mask_in, fast_mask_in, req_valid_in, req_write_in, want_bus_in} = 6'h00;
		{ready_in, irq_n_in, fast_n_in, bad} = 4'he;
		req_addr_in = 16'h0000;
		req_wdata_in = 8'h00;
		mem_data_in = 8'ha5;
		repeat (16) tick();
		check("reset addr", bus_if.addr, cbt_pkg::IDLE_ADDR);
		nrst_in = 1'h1;
		repeat (8) tick();
		start_cycle(1'h1, 16'h1234, 8'h5a);
		check("wdata", bus_if.data_to_mem, 8'h5a);
		wait_done();
		// slow memory: e must stay high while ready is low
		ready_in = 1'h0;
		start_cycle(1'h0, 16'h0040, 8'h00);
		repeat (8) tick();
		check("stretched e", {bus_if.e_clk, bus_if.q_clk}, 2'h2);
		ready_in = 1'h1;
		wait_done();
		check("read data", rd_data_out, 8'ha5);
		// grant, refresh retrieval, then return
		want_bus_in = 1'h1;
		for (n = 0; n < 20 && !bus_if.bus_released; n++) tick();
		need(bus_if.bus_released);
		check("grant pair", {bus_if.bus_released, bus_if.bus_state_flag}, 2'h3);
		check("halted", halted_out, 1'h1);
		check("dead cycle mem", mem_enable_out, 1'h0);
		repeat (8) tick();
		check("dma owns", owns_bus_out, 1'h1);
		for (n = 0; n < 80 && bus_if.bus_released; n++) tick();
		check("refresh taken", bus_if.bus_released, 1'h0);
		check("dma off bus", owns_bus_out, 1'h0);
		check("refresh lead dead", bus_if.valid_memory_access, 1'h0);
		for (n = 0; n < 16 && !bus_if.bus_released; n++) tick();
		check("regranted", bus_if.bus_released, 1'h1);
		want_bus_in = 1'h0;
		for (n = 0; n < 20 && bus_if.bus_released; n++) tick();
		need(!bus_if.bus_released);
		start_cycle(1'h1, 16'h2000, 8'h3c);
		wait_done();
		// masked general request is never taken
		irq_mask_in = 1'h1;
		irq_n_in = 1'h0;
		repeat (40) begin
			tick();
			bad = bad | (irq_taken_out !== 2'h0);
		end
		check("masked irq", bad, 1'h0);
		irq_mask_in = 1'h0;
		fast_n_in = 1'h0;
		for (n = 0; n < 40 && irq_taken_out == 2'h0; n++) tick();
		check("fast first", irq_taken_out, 2'h2);
		check("fast push", push_count_out, cbt_pkg::PUSH_FAST);
		fast_n_in = 1'h1;
		tick();
		for (n = 0; n < 40 && irq_taken_out !== 2'h1; n++) tick();
		check("general", irq_taken_out, 2'h1);
		check("full push", push_count_out, cbt_pkg::PUSH_FULL);
		irq_n_in = 1'h1;
		give_verdict();
	end
endmodule // testbench
